// ### include/dpr_axi_if.sv
// AXI4 write channels between the bus master and the memory.
// Assumes one clock shared by both ends; read channels are absent.
`timescale 1ns/100ps
`include "dpr_defines.svh"

interface dpr_axi_if;
    logic [`DPR_ID_W-1:0] awid;
    logic [31:0] awaddr;
    logic [`DPR_LEN_W-1:0] awlen;
    logic [`DPR_SIZE_W-1:0] awsize;
    logic [1:0] awburst;
    logic awvalid;
    logic awready;
    logic [`DPR_DATA_W-1:0] wdata;
    logic [`DPR_LANES-1:0] wstrb;
    logic wlast;
    logic wvalid;
    logic wready;
    logic [`DPR_ID_W-1:0] bid;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;

    modport dev (
        input awid, awaddr, awlen, awsize, awburst, awvalid,
        output awready,
        input wdata, wstrb, wlast, wvalid,
        output wready,
        output bid, bresp, bvalid,
        input bready
    );

    modport mst (
        output awid, awaddr, awlen, awsize, awburst, awvalid,
        input awready,
        output wdata, wstrb, wlast, wvalid,
        input wready,
        input bid, bresp, bvalid,
        output bready
    );
endinterface

// ### include/dpr_defines.svh
// Constants for the dual-port memory with AXI4 write path.
// Assumes inclusion by bare name from both ends and the interface.
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

`define DPR_DATA_W 32
`define DPR_LANES 4
`define DPR_LANE_W 8
`define DPR_CODE_W 13
`define DPR_ADDR_W 8
`define DPR_DEPTH 256
`define DPR_ID_W 4
`define DPR_LEN_W 8
`define DPR_SIZE_W 3
`define DPR_FULL_SIZE 3'h2
`define DPR_BURST_FIXED 2'h0
`define DPR_BURST_INCR 2'h1
`define DPR_BURST_WRAP 2'h2
`define DPR_RESP_OKAY 2'h0
`define DPR_WORD_LSB 2

`endif

// ### include/dpr_pkg.sv
// Types shared by both ends of the memory write path.
// Assumes dpr_defines.svh is on the include path.
`include "dpr_defines.svh"

package dpr_pkg;

    typedef enum logic [1:0] {
        DPR_S_IDLE = 2'h0,
        DPR_S_DATA = 2'h1,
        DPR_S_RESP = 2'h3
    } dpr_slv_state_t;

    typedef enum logic [1:0] {
        DPR_M_IDLE = 2'h0,
        DPR_M_ADDR = 2'h1,
        DPR_M_DATA = 2'h3,
        DPR_M_RESP = 2'h2
    } dpr_mst_state_t;

    typedef struct packed {
        logic [`DPR_LANE_W-1:0] data;
        logic sbe;
        logic dbe;
    } dpr_dec_t;

    // SECDED per byte lane: data on non-power-of-two positions, overall parity at 0
    function automatic logic [`DPR_CODE_W-1:0] dpr_enc(input logic [`DPR_LANE_W-1:0] d);
        logic [`DPR_CODE_W-1:0] c;
        int k;
        c = '0;
        k = 0;
        for (int p = 1; p < `DPR_CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[k];
                k++;
            end
        end
        for (int i = 0; i < 4; i++) begin
            for (int p = 1; p < `DPR_CODE_W; p++) begin
                if (((p >> i) & 1) == 1) begin
                    c[1 << i] = c[1 << i] ^ c[p];
                end
            end
        end
        c[0] = ^c[`DPR_CODE_W-1:1];
        return c;
    endfunction

    function automatic dpr_dec_t dpr_dec(input logic [`DPR_CODE_W-1:0] cin);
        logic [`DPR_CODE_W-1:0] c;
        logic [3:0] syn;
        logic ovr;
        dpr_dec_t r;
        int k;
        c = cin;
        syn = '0;
        r = '0;
        k = 0;
        for (int i = 0; i < 4; i++) begin
            for (int p = 1; p < `DPR_CODE_W; p++) begin
                if (((p >> i) & 1) == 1) begin
                    syn[i] = syn[i] ^ c[p];
                end
            end
        end
        ovr = ^c;
        if (ovr) begin
            r.sbe = 1'b1;
            if (syn != 4'h0 && syn < 4'hD) begin
                c[syn] = ~c[syn];
            end
        end else if (syn != 4'h0) begin
            r.dbe = 1'b1;
        end
        for (int p = 1; p < `DPR_CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                r.data[k] = c[p];
                k++;
            end
        end
        return r;
    endfunction

endpackage

// ### src/dpr_master.sv
// AXI4 write master that feeds the memory's write slave.
// Assumes a user command port and a beat stream on the same clock.
`timescale 1ns/100ps
`include "dpr_defines.svh"

module dpr_master (
    input wire logic clock,
    input wire logic rst_n,
    dpr_axi_if.mst axi,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [31:0] cmd_addr,
    input wire logic [`DPR_LEN_W-1:0] cmd_len,
    input wire logic [`DPR_SIZE_W-1:0] cmd_size,
    input wire logic [1:0] cmd_burst,
    input wire logic [`DPR_ID_W-1:0] cmd_id,
    input wire logic beat_valid,
    output logic beat_ready,
    input wire logic [`DPR_DATA_W-1:0] beat_data,
    input wire logic [`DPR_LANES-1:0] beat_strb,
    output logic done,
    output logic [`DPR_ID_W-1:0] done_id,
    output logic [1:0] done_resp
);

    dpr_pkg::dpr_mst_state_t state_r;
    logic [`DPR_LEN_W-1:0] len_r;
    logic [`DPR_LEN_W-1:0] cnt_r;
    logic beat_take;
    logic w_fire;

    assign beat_take = beat_ready & beat_valid;
    assign w_fire = axi.wvalid & axi.wready;

    ////////////////////////////////////////////////////////////////////////
    // One burst at a time; a new command waits for the response
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= dpr_pkg::DPR_M_IDLE;
            cmd_ready <= 1'b0;
            axi.awvalid <= 1'b0;
            axi.bready <= 1'b0;
            beat_ready <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_r)
                dpr_pkg::DPR_M_IDLE: begin
                    cmd_ready <= ~(cmd_valid & cmd_ready);
                    if (cmd_valid && cmd_ready) begin
                        state_r <= dpr_pkg::DPR_M_ADDR;
                        axi.awvalid <= 1'b1;
                    end
                end
                dpr_pkg::DPR_M_ADDR: begin
                    if (axi.awready) begin
                        state_r <= dpr_pkg::DPR_M_DATA;
                        axi.awvalid <= 1'b0;
                        beat_ready <= 1'b1;
                    end
                end
                dpr_pkg::DPR_M_DATA: begin
                    if (beat_take) begin
                        beat_ready <= 1'b0;
                    end else if (w_fire && !axi.wlast) begin
                        beat_ready <= 1'b1;
                    end
                    if (w_fire && axi.wlast) begin
                        state_r <= dpr_pkg::DPR_M_RESP;
                        axi.bready <= 1'b1;
                    end
                end
                dpr_pkg::DPR_M_RESP: begin
                    if (axi.bvalid) begin
                        state_r <= dpr_pkg::DPR_M_IDLE;
                        axi.bready <= 1'b0;
                        cmd_ready <= 1'b1;
                        done <= 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address channel stays frozen from issue until accepted
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            axi.awid <= '0;
            axi.awaddr <= '0;
            axi.awlen <= '0;
            axi.awsize <= `DPR_FULL_SIZE;
            axi.awburst <= `DPR_BURST_INCR;
            len_r <= '0;
        end else if (cmd_valid && cmd_ready) begin
            axi.awid <= cmd_id;
            axi.awaddr <= cmd_addr;
            axi.awlen <= cmd_len;
            // Oversized requests are clipped to the bus width
            axi.awsize <= (cmd_size > `DPR_FULL_SIZE) ? `DPR_FULL_SIZE : cmd_size;
            axi.awburst <= cmd_burst;
            len_r <= cmd_len;
        end
    end

    // Half rate on W: one beat register, no skid, kept small on purpose
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            axi.wvalid <= 1'b0;
            axi.wlast <= 1'b0;
            axi.wdata <= '0;
            axi.wstrb <= '0;
            cnt_r <= '0;
        end else if (beat_take) begin
            axi.wvalid <= 1'b1;
            axi.wdata <= beat_data;
            axi.wstrb <= beat_strb;
            axi.wlast <= (cnt_r == len_r);
            cnt_r <= cnt_r + 8'h01;
        end else if (w_fire) begin
            axi.wvalid <= 1'b0;
            axi.wlast <= 1'b0;
            if (axi.wlast) begin
                cnt_r <= '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_id <= '0;
            done_resp <= `DPR_RESP_OKAY;
        end else if (axi.bvalid && axi.bready) begin
            done_id <= axi.bid;
            done_resp <= axi.bresp;
        end
    end

endmodule // dpr_master

// ### src/dpr_mem.sv
// Dual-port byte-lane SECDED memory with an AXI4 write slave.
// Assumes one clock for both native ports and the AXI side.
`timescale 1ns/100ps
`include "dpr_defines.svh"

module dpr_mem #(
    parameter bit MEM_SLAVE = 1'b1,
    parameter bit ID_EN = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    dpr_axi_if.dev axi,
    input wire logic a_en,
    input wire logic [`DPR_LANES-1:0] a_we,
    input wire logic [`DPR_ADDR_W-1:0] a_addr,
    input wire logic [`DPR_DATA_W-1:0] a_din,
    input wire logic a_rst,
    input wire logic a_regce,
    output logic [`DPR_DATA_W-1:0] a_dout,
    input wire logic b_en,
    input wire logic [`DPR_LANES-1:0] b_we,
    input wire logic [`DPR_ADDR_W-1:0] b_addr,
    input wire logic [`DPR_DATA_W-1:0] b_din,
    input wire logic b_rst,
    input wire logic b_regce,
    output logic [`DPR_DATA_W-1:0] b_dout,
    input wire logic inj_sbit,
    input wire logic inj_dbit,
    output logic sbit_err,
    output logic dbit_err,
    output logic [`DPR_ADDR_W-1:0] err_addr
);

    ////////////////////////////////////////////////////////////////////////
    // Each lane holds its own SECDED codeword, so byte writes need no read-modify-write

    ////////////////////////////////////////////////////////////////////////
    // Storage and write ports
    logic [`DPR_LANES-1:0][`DPR_CODE_W-1:0] mem [`DPR_DEPTH];
    logic [`DPR_LANES-1:0][`DPR_CODE_W-1:0] a_code;
    logic [`DPR_LANES-1:0][`DPR_CODE_W-1:0] b_code;
    logic [`DPR_LANES-1:0][`DPR_CODE_W-1:0] x_code;
    logic [`DPR_CODE_W-1:0] inj_mask;
    logic w_fire;
    logic [31:0] addr_r;

    // Injection flips data bits of lane 0 on port A writes, so a missed fix shows
    assign inj_mask = inj_dbit ? 13'h0028 : (inj_sbit ? 13'h0008 : 13'h0000);

    genvar g;
    generate
        for (g = 0; g < `DPR_LANES; g++) begin : g_enc
            assign a_code[g] = dpr_pkg::dpr_enc(a_din[g*8 +: 8])
                ^ ((g == 0) ? inj_mask : 13'h0000);
            assign b_code[g] = dpr_pkg::dpr_enc(b_din[g*8 +: 8]);
            assign x_code[g] = dpr_pkg::dpr_enc(axi.wdata[g*8 +: 8]);
        end
    endgenerate

    // Same-word collision: AXI beats win over port A, port A over port B
    always_ff @(posedge clock) begin
        for (int l = 0; l < `DPR_LANES; l++) begin
            if (b_en && b_we[l]) begin
                mem[b_addr][l] <= b_code[l];
            end
            if (a_en && a_we[l]) begin
                mem[a_addr][l] <= a_code[l];
            end
            if (w_fire && axi.wstrb[l]) begin
                mem[addr_r[`DPR_WORD_LSB +: `DPR_ADDR_W]][l] <= x_code[l];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read paths: latch stage then output register stage
    dpr_pkg::dpr_dec_t b_dec [`DPR_LANES];
    logic [`DPR_LANES-1:0][`DPR_CODE_W-1:0] b_word;
    logic [`DPR_DATA_W-1:0] a_lat_r;
    logic [`DPR_DATA_W-1:0] b_lat_r;
    logic b_sbe_lat_r;
    logic b_dbe_lat_r;
    logic [`DPR_ADDR_W-1:0] b_addr_lat_r;
    logic [`DPR_DATA_W-1:0] a_word;
    logic [`DPR_DATA_W-1:0] b_data;
    logic [`DPR_LANES-1:0] b_sbe;
    logic [`DPR_LANES-1:0] b_dbe;

    assign b_word = mem[b_addr];
    generate
        for (g = 0; g < `DPR_LANES; g++) begin : g_dec
            dpr_pkg::dpr_dec_t a_dec;
            assign a_dec = dpr_pkg::dpr_dec(mem[a_addr][g]);
            assign a_word[g*8 +: 8] = a_dec.data;
            assign b_dec[g] = dpr_pkg::dpr_dec(b_word[g]);
            assign b_data[g*8 +: 8] = b_dec[g].data;
            assign b_sbe[g] = b_dec[g].sbe;
            assign b_dbe[g] = b_dec[g].dbe;
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (a_en) begin
            a_lat_r <= a_rst ? '0 : a_word;
        end
    end

    always_ff @(posedge clock) begin
        if (a_en && a_rst) begin
            a_dout <= '0;
        end else if (a_en && a_regce) begin
            a_dout <= a_lat_r;
        end
    end

    always_ff @(posedge clock) begin
        if (b_en) begin
            b_lat_r <= b_rst ? '0 : b_data;
            b_sbe_lat_r <= ~b_rst & (|b_sbe) & ~(|b_dbe);
            b_dbe_lat_r <= ~b_rst & (|b_dbe);
            b_addr_lat_r <= b_addr;
        end
    end

    always_ff @(posedge clock) begin
        if (b_en && b_rst) begin
            b_dout <= '0;
            sbit_err <= 1'b0;
            dbit_err <= 1'b0;
            err_addr <= '0;
        end else if (b_en && b_regce) begin
            b_dout <= b_lat_r;
            sbit_err <= b_sbe_lat_r;
            dbit_err <= b_dbe_lat_r;
            err_addr <= b_addr_lat_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4 write slave
    dpr_pkg::dpr_slv_state_t state_r;
    logic [`DPR_LEN_W-1:0] len_r;
    logic [`DPR_LEN_W-1:0] cnt_r;
    logic [`DPR_SIZE_W-1:0] size_r;
    logic [1:0] burst_r;
    logic [`DPR_ID_W-1:0] id_r;
    logic aw_fire;
    logic last_beat;
    logic [31:0] step;
    logic [31:0] wrap_mask;
    logic [31:0] addr_nxt;

    assign aw_fire = axi.awvalid & axi.awready;
    assign w_fire = axi.wvalid & axi.wready;
    assign last_beat = (cnt_r == len_r);

    // Next beat address; only INCR bursts realign it to the transfer size
    always_comb begin
        step = 32'h1 << size_r;
        wrap_mask = ({24'h0, len_r} + 32'h1) * step - 32'h1;
        addr_nxt = (addr_r & ~(step - 32'h1)) + step;
        if (burst_r == `DPR_BURST_WRAP) begin
            addr_nxt = (addr_r & ~wrap_mask) | ((addr_r + step) & wrap_mask);
        end else if (burst_r == `DPR_BURST_FIXED) begin
            addr_nxt = addr_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= dpr_pkg::DPR_S_IDLE;
            axi.awready <= 1'b0;
            axi.wready <= 1'b0;
            axi.bvalid <= 1'b0;
        end else begin
            unique case (state_r)
                dpr_pkg::DPR_S_IDLE: begin
                    axi.awready <= ~aw_fire;
                    if (aw_fire) begin
                        state_r <= dpr_pkg::DPR_S_DATA;
                        axi.wready <= 1'b1;
                    end
                end
                dpr_pkg::DPR_S_DATA: begin
                    if (w_fire && last_beat) begin
                        state_r <= dpr_pkg::DPR_S_RESP;
                        axi.wready <= 1'b0;
                        axi.bvalid <= 1'b1;
                    end
                end
                dpr_pkg::DPR_S_RESP: begin
                    if (axi.bready) begin
                        state_r <= dpr_pkg::DPR_S_IDLE;
                        axi.bvalid <= 1'b0;
                        axi.awready <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_r <= '0;
            len_r <= '0;
            cnt_r <= '0;
            size_r <= `DPR_FULL_SIZE;
            burst_r <= `DPR_BURST_INCR;
            id_r <= '0;
        end else if (aw_fire) begin
            addr_r <= axi.awaddr;
            len_r <= axi.awlen;
            cnt_r <= '0;
            // Peripheral variant ignores size, burst type and ID
            size_r <= MEM_SLAVE ? axi.awsize : `DPR_FULL_SIZE;
            burst_r <= MEM_SLAVE ? axi.awburst : `DPR_BURST_INCR;
            id_r <= (MEM_SLAVE && ID_EN) ? axi.awid : '0;
        end else if (w_fire) begin
            addr_r <= addr_nxt;
            cnt_r <= cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            axi.bid <= '0;
            axi.bresp <= `DPR_RESP_OKAY;
        end else begin
            axi.bid <= id_r;
            axi.bresp <= `DPR_RESP_OKAY;
        end
    end

endmodule // dpr_mem

// ### verif/dpr_bench.sv
// Bench: memory and AXI4 write master joined back to back, native ports driven directly.
// Assumes one 100 MHz clock and the shared defines on the include path.
`timescale 1ns/100ps
`include "dpr_defines.svh"

module dpr_bench;
    logic clock, rst_n, a_en, a_rst, a_regce, b_en, b_rst, b_regce, inj_sbit, inj_dbit;
    logic [3:0] a_we, b_we, beat_strb, cmd_id, done_id;
    logic [7:0] a_addr, b_addr, err_addr, cmd_len;
    logic [31:0] a_din, b_din, a_dout, b_dout, beat_data, cmd_addr;
    logic sbit_err, dbit_err, cmd_valid, cmd_ready, beat_valid, beat_ready, done;
    logic [1:0] cmd_burst, done_resp;
    logic [2:0] cmd_size;
    int n_errors, n_checks;

    dpr_axi_if axi_if();
    dpr_mem #(.MEM_SLAVE(1'h1), .ID_EN(1'h1)) dpr_mem_inst (.clock(clock), .rst_n(rst_n),
        .axi(axi_if), .a_en(a_en), .a_we(a_we), .a_addr(a_addr), .a_din(a_din), .a_rst(a_rst),
        .a_regce(a_regce), .a_dout(a_dout), .b_en(b_en), .b_we(b_we), .b_addr(b_addr),
        .b_din(b_din), .b_rst(b_rst), .b_regce(b_regce), .b_dout(b_dout), .inj_sbit(inj_sbit),
        .inj_dbit(inj_dbit), .sbit_err(sbit_err), .dbit_err(dbit_err), .err_addr(err_addr));
    dpr_master dpr_master_inst (.clock(clock), .rst_n(rst_n), .axi(axi_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .cmd_size(cmd_size), .cmd_burst(cmd_burst), .cmd_id(cmd_id), .beat_valid(beat_valid),
        .beat_ready(beat_ready), .beat_data(beat_data), .beat_strb(beat_strb), .done(done),
        .done_id(done_id), .done_resp(done_resp));
    dpr_monitor dpr_monitor_inst (.clock(clock), .rst_n(rst_n), .awid(axi_if.awid),
        .awaddr(axi_if.awaddr), .awlen(axi_if.awlen), .awburst(axi_if.awburst),
        .awvalid(axi_if.awvalid), .awready(axi_if.awready), .wlast(axi_if.wlast),
        .wvalid(axi_if.wvalid), .wready(axi_if.wready), .bid(axi_if.bid), .bresp(axi_if.bresp),
        .bvalid(axi_if.bvalid), .bready(axi_if.bready));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Bounded wait on command ready (0), beat ready (1) or done (2)
    task automatic wait_hs(input int w);
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (!((w == 0) ? cmd_ready : (w == 1) ? beat_ready : done) && k < 300);
        if (k >= 300) begin
            n_errors++;
            $display("BAD handshake expected 1 seen 0");
            wrap_up();
        end
    endtask

    task automatic wr(input bit pb, input logic [7:0] ad, input logic [3:0] we,
                      input logic [31:0] d, input logic en, input logic [1:0] inj);
        @(posedge clock);
        if (pb) begin
            {b_en, b_we, b_addr, b_din} <= {en, we, ad, d};
        end else begin
            {a_en, a_we, a_addr, a_din, inj_dbit, inj_sbit} <= {en, we, ad, d, inj};
        end
        @(posedge clock);
        {a_en, b_en, a_we, b_we, inj_dbit, inj_sbit} <= 12'h000;
    endtask

    // Output stands two edges after the read is taken
    task automatic rd(input bit pb, input logic [7:0] ad, input logic ce);
        @(posedge clock);
        if (pb) begin
            {b_en, b_addr, b_regce} <= {1'h1, ad, ce};
        end else begin
            {a_en, a_addr, a_regce} <= {1'h1, ad, ce};
        end
        repeat (2) @(posedge clock);
        {a_en, b_en} <= 2'h0;
        #1;
    endtask

    task automatic rst_a(input logic en);
        @(posedge clock);
        {a_en, a_rst, a_regce} <= {en, 2'h2};
        repeat (2) @(posedge clock);
        {a_en, a_rst} <= 2'h0;
        #1;
    endtask

    task automatic axi_burst(input logic [31:0] ad, input logic [7:0] ln, input logic [1:0] bt,
                             input logic [3:0] id, input logic [31:0] base, input logic [3:0] sb1);
        @(posedge clock);
        {cmd_addr, cmd_len, cmd_burst, cmd_id} <= {ad, ln, bt, id};
        cmd_valid <= 1'h1;
        wait_hs(0);
        cmd_valid <= 1'h0;
        for (int i = 0; i <= ln; i++) begin
            beat_data <= base + i;
            beat_strb <= (i == 1) ? sb1 : 4'hF;
            beat_valid <= 1'h1;
            wait_hs(1);
        end
        beat_valid <= 1'h0;
        wait_hs(2);
        chk("done_id", done_id, id);
        chk("done_resp", done_resp, `DPR_RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, a_en, a_rst, a_regce, b_en, b_rst, b_regce, inj_sbit, inj_dbit} = 9'h000;
        {a_we, b_we, beat_strb, cmd_id, a_addr, b_addr, cmd_len} = 40'h0;
        {a_din, b_din, beat_data, cmd_addr} = 128'h0;
        {cmd_valid, beat_valid, cmd_burst} = 4'h0;
        cmd_size = `DPR_FULL_SIZE;
        n_errors = 0;
        n_checks = 0;
        repeat (8) @(posedge clock);
        rst_n <= 1'h1;

        wr(0, 8'h20, 4'hF, 32'h11223344, 1'h1, 2'h0);
        wr(1, 8'h20, 4'h2, 32'hAABBCCDD, 1'h1, 2'h0);
        rd(1, 8'h20, 1'h1);
        chk("b_dout", b_dout, 32'h1122CC44);
        wr(0, 8'h20, 4'hF, 32'h0, 1'h0, 2'h0);
        rd(0, 8'h20, 1'h1);
        chk("a_dout", a_dout, 32'h1122CC44);
        rst_a(1'h0);
        chk("a_dout", a_dout, 32'h1122CC44);
        rst_a(1'h1);
        chk("a_dout", a_dout, 32'h0);
        rd(0, 8'h20, 1'h0);
        chk("a_dout", a_dout, 32'h0);
        rd(1, 8'h20, 1'h1);
        chk("b_dout", b_dout, 32'h1122CC44);
        $display("test native done");

        wr(0, 8'h40, 4'hF, 32'hA5A5A5A5, 1'h1, 2'h1);
        rd(1, 8'h40, 1'h1);
        chk("b_dout", b_dout, 32'hA5A5A5A5);
        chk("sbit_err", sbit_err, 1'h1);
        chk("dbit_err", dbit_err, 1'h0);
        chk("err_addr", err_addr, 8'h40);
        wr(0, 8'h41, 4'hF, 32'h5A5A5A5A, 1'h1, 2'h2);
        rd(1, 8'h41, 1'h1);
        chk("dbit_err", dbit_err, 1'h1);
        chk("err_addr", err_addr, 8'h41);
        rd(1, 8'h20, 1'h1);
        chk("sbit_err", sbit_err, 1'h0);
        $display("test ecc done");

        // Lanes 1 and 3 of word 1 keep this preload
        wr(0, 8'h01, 4'hF, 32'hFFFFFFFF, 1'h1, 2'h0);
        axi_burst(32'h0, 8'h03, `DPR_BURST_INCR, 4'h5, 32'h10000000, 4'h5);
        for (int i = 0; i < 4; i++) begin
            rd(1, i[7:0], 1'h1);
            chk("incr_word", b_dout, (i == 1) ? 32'hFF00FF01 : 32'h10000000 + i);
        end
        axi_burst(32'h38, 8'h03, `DPR_BURST_WRAP, 4'hA, 32'h20000000, 4'hF);
        for (int i = 0; i < 4; i++) begin
            rd(1, 8'h0C + i[7:0], 1'h1);
            chk("wrap_word", b_dout, 32'h20000000 + ((i + 2) % 4));
        end
        // Oversized size is clipped to the bus width; a fixed burst stays on one word
        @(posedge clock);
        cmd_size <= 3'h7;
        axi_burst(32'h100, 8'h01, `DPR_BURST_INCR, 4'h3, 32'h40000000, 4'hF);
        axi_burst(32'h108, 8'h01, `DPR_BURST_FIXED, 4'h6, 32'h50000000, 4'hF);
        for (int i = 0; i < 3; i++) begin
            rd(1, 8'h40 + i[7:0], 1'h1);
            chk("clip_fixed", b_dout, (i == 2) ? 32'h50000001 : 32'h40000000 + i);
        end
        $display("test bursts done");

        // Reset in mid-run, then a single beat at the top word
        @(posedge clock);
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        axi_burst(32'h3FC, 8'h00, `DPR_BURST_INCR, 4'hF, 32'h30000000, 4'hF);
        rd(1, 8'hFF, 1'h1);
        chk("last_word", b_dout, 32'h30000000);
        $display("test reset and single beat done");
        wrap_up();
    end
endmodule // dpr_bench

// ### verif/dpr_monitor.sv
// Checker for the AXI4 write channels between the master and the memory.
// Assumes one clock, synchronous active-low reset, one burst at a time.
`timescale 1ns/100ps
`include "dpr_defines.svh"

module dpr_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [`DPR_ID_W-1:0] awid,
    input wire logic [31:0] awaddr,
    input wire logic [`DPR_LEN_W-1:0] awlen,
    input wire logic [1:0] awburst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wlast,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [`DPR_ID_W-1:0] bid,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready
);
    ////////////////////////////////////////////////////////////////////////////
    logic [`DPR_ID_W-1:0] id_r;
    logic [`DPR_LEN_W-1:0] len_r;
    logic [`DPR_LEN_W-1:0] cnt_r;

    // Burst tag and length kept from the address handshake
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            id_r <= '0;
            len_r <= '0;
        end else if (awvalid && awready) begin
            id_r <= awid;
            len_r <= awlen;
        end
    end

    // Beats accepted so far in the current burst
    always_ff @(posedge clock) begin
        if (!rst_n || (awvalid && awready)) begin
            cnt_r <= '0;
        end else if (wvalid && wready) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_aw_busy_low: assert property (awvalid && awready |=> !awready)
        else $error("address accepted while a burst is open");
    a_wready_after_aw: assert property (awvalid && awready |=> wready)
        else $error("data channel not opened after address");
    a_last_on_count: assert property (wvalid && wready && wlast |-> cnt_r == len_r)
        else $error("last flag on a beat other than the final one");
    a_resp_after_last: assert property (wvalid && wready && cnt_r == len_r |=> bvalid && !wready)
        else $error("no response right after the final beat");
    a_resp_okay: assert property (bvalid |-> bresp == `DPR_RESP_OKAY)
        else $error("response code not okay");
    a_bid_echo: assert property (bvalid |-> bid == id_r)
        else $error("response tag differs from address tag");
    a_resp_held: assert property (bvalid && !bready |=> bvalid && $stable(bid) && $stable(bresp))
        else $error("response dropped or changed before accepted");
    a_resp_single: assert property (bvalid && bready |=> !bvalid [*2])
        else $error("second response for one burst");
    a_aw_hold: assert property (awvalid && !awready |=> awvalid && $stable(awaddr) && $stable(awlen))
        else $error("address changed before accepted");

    c_wrap: cover property (awvalid && awready && awburst == `DPR_BURST_WRAP);
    c_mid_beat: cover property (wvalid && wready && !wlast);
    c_resp: cover property (bvalid && bready);
endmodule // dpr_monitor
